// >>> rtl/umode_top.sv
// UART with mode register: auto-baud, polarity, oversampling, framing.
//
// Overview of operation
// - Auto-baud measures rate on next 55h character
// - Hardware clears auto-baud bit when measurement ends
// - Invert bit makes receive idle level zero
// - High-speed bit gives four ticks per bit
// - Clear high-speed bit gives sixteen ticks
// - Field 11 nine bits, 00 eight bits
// - Field 10 odd, 01 even parity
`timescale 1ns/1ps
`include "umode_defines.svh"
module umode_top import umode_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input wire logic serial_receive_line,
  output logic serial_transmit_line
);
  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  logic [15:0] mode_q; // Mode fields, low six bits implemented.
  logic [15:0] div_q; // Baud generator divisor, ticks minus one.
  logic [8:0] txd_q; // Character waiting to go out.
  logic tx_pend_q; // Transmit request pending.
  logic [8:0] rxd_q; // Last received character.
  logic rx_full_q; // Receive data valid, cleared by read.
  logic perr_q; // Parity error of last character.
  logic ferr_q; // Framing error of last character.
  logic [31:0] prdata_q; // Registered read data.
  umode_cfg_t cfg;
  assign cfg.auto_rate_measure_enable = mode_q[`UMODE_BIT_AUTO_RATE_MEASURE_ENABLE];
  assign cfg.rx_idle_polarity_invert = mode_q[`UMODE_BIT_INV];
  assign cfg.high_speed_oversample_select = mode_q[`UMODE_BIT_HS];
  assign cfg.data_parity_select = umode_dps_t'(mode_q[2:1]);
  assign cfg.stop_bit_count_select = mode_q[`UMODE_BIT_STOP];
  // Bus decode of the address and of the access phase.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_mode = paddr == `UMODE_OFF_MODE;
  wire hit_div = paddr == `UMODE_OFF_DIV;
  wire hit_tx = paddr == `UMODE_OFF_TXDATA;
  wire hit_rx = paddr == `UMODE_OFF_RXDATA;
  wire hit_st = paddr == `UMODE_OFF_STATUS;
  wire unmapped = ~(hit_mode | hit_div | hit_tx | hit_rx | hit_st);
  // Reads wait one cycle so that prdata comes straight from a flip-flop;
  // writes answer in their first access cycle.
  logic rd_ack_q; // Read data latched, the access may end.
  wire rd_first = rd & ~rd_ack_q;
  assign pready = ~rd | rd_ack_q;
  // The wait flag stands for exactly one cycle of each read.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_first;
    end
  end
  assign pslverr = acc & unmapped;
  assign prdata = prdata_q;
  // --------------------------------------------------------------------
  // Framing helpers
  // --------------------------------------------------------------------
  // Number of data bits for a selection.
  function automatic logic [3:0] nbits(input umode_dps_t s);
    nbits = (s == UMODE_D9_NONE) ? 4'h9 : 4'h8;
  endfunction
  // Parity bit expected or sent for eight data bits.
  function automatic logic parbit(input umode_dps_t s, input logic [7:0] d);
    parbit = (s == UMODE_D8_ODD) ? ~(^d) : (^d);
  endfunction
  wire par_on = (cfg.data_parity_select == UMODE_D8_EVEN) |
                (cfg.data_parity_select == UMODE_D8_ODD);
  wire [4:0] ovs = cfg.high_speed_oversample_select ?
                   `UMODE_OVS_HS : `UMODE_OVS_STD;
  wire [4:0] ovs_half = {1'b0, ovs[4:1]};
  // --------------------------------------------------------------------
  // Baud generator: one tick every div_q+1 clocks
  // --------------------------------------------------------------------
  logic [15:0] bcnt_q;
  wire tick = bcnt_q == 16'h0000;
  // Counter reloads from the divisor each time it reaches zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q <= 16'h0000;
    end else begin
      bcnt_q <= tick ? div_q : bcnt_q - 16'h0001;
    end
  end
  // --------------------------------------------------------------------
  // Receive pin synchroniser and polarity
  // --------------------------------------------------------------------
  logic [2:0] rx_sync_q;
  logic rx_line_q; // Filtered line, already in idle-high sense.
  // Change accepted only when stages two and three agree.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_q <= 3'h7;
      rx_line_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], serial_receive_line};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_line_q <= rx_sync_q[2] ^ cfg.rx_idle_polarity_invert;
      end
    end
  end
  // --------------------------------------------------------------------
  // Auto-baud measurement
  // --------------------------------------------------------------------
  // A 55h sync character gives five falling edges; start to fifth
  // spans eight bit times, so the count divided by 8*ovs, minus one, is the divisor.
  // The remote must send 55h first, otherwise the result is garbage.
  logic line_d_q; // Previous filtered line for edge detection.
  logic [2:0] ab_edges_q; // Falling edges seen in the sync field.
  logic [23:0] ab_cnt_q; // Clocks since the start edge.
  wire fall = line_d_q & ~rx_line_q;
  wire ab_done = cfg.auto_rate_measure_enable & fall &
                 (ab_edges_q == `UMODE_SYNC_EDGES);
  // The count stops one short of the span, since the fifth edge cycle is not added.
  wire [23:0] ab_span = ab_cnt_q + 24'h000001;
  wire [23:0] ab_div = cfg.high_speed_oversample_select ?
                       (ab_span >> 5) : (ab_span >> 7);
  // Edge count and clock count run only while measuring.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_d_q <= 1'b1;
      ab_edges_q <= 3'h0;
      ab_cnt_q <= 24'h000000;
    end else begin
      line_d_q <= rx_line_q;
      if (!cfg.auto_rate_measure_enable || ab_done) begin
        ab_edges_q <= 3'h0;
        ab_cnt_q <= 24'h000000;
      end else if (fall) begin
        ab_edges_q <= ab_edges_q + 3'h1;
        ab_cnt_q <= (ab_edges_q == 3'h0) ? 24'h000000 : ab_cnt_q + 24'h000001;
      end else if (ab_edges_q != 3'h0) begin
        ab_cnt_q <= ab_cnt_q + 24'h000001;
      end
    end
  end
  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  umode_st_t rst_q; // Receive state.
  logic [4:0] rsub_q; // Tick count inside a bit.
  logic [3:0] ridx_q; // Data bit index.
  logic [8:0] rsh_q; // Shift register, LSB first.
  logic rstop_q; // Second stop bit pending.
  wire rmid = tick & (rsub_q == ovs - 5'h01);
  wire rx_run = ~cfg.auto_rate_measure_enable; // Sync character is not data.
  wire rx_done = (rst_q == UMODE_STOP) & rmid & ~(rstop_q & rx_line_q);
  wire rx_perr_d = par_on & (rsh_q[8] != parbit(cfg.data_parity_select, rsh_q[7:0]));
  // Only the nine-bit mode hands bit 8 on; a received parity bit stays inside.
  wire [8:0] rx_char = (cfg.data_parity_select == UMODE_D9_NONE) ?
                       rsh_q : {1'b0, rsh_q[7:0]};
  // Receive state machine, centre-sampled.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= UMODE_IDLE;
      rsub_q <= 5'h00;
      ridx_q <= 4'h0;
      rsh_q <= 9'h000;
      rstop_q <= 1'b0;
    end else begin
      if (tick) begin
        rsub_q <= rmid ? 5'h00 : rsub_q + 5'h01;
      end
      case (rst_q)
        UMODE_IDLE: begin
          if (rx_run && fall) begin
            rst_q <= UMODE_START;
            rsub_q <= ovs - ovs_half; // Next wrap lands mid start bit.
          end
        end
        UMODE_START: begin
          if (rmid) begin
            rst_q <= rx_line_q ? UMODE_IDLE : UMODE_DATA;
            ridx_q <= 4'h0;
            rsh_q <= 9'h000;
          end
        end
        UMODE_DATA: begin
          if (rmid) begin
            rsh_q[ridx_q] <= rx_line_q;
            ridx_q <= ridx_q + 4'h1;
            if (ridx_q == nbits(cfg.data_parity_select) - 4'h1) begin
              rst_q <= par_on ? UMODE_PAR : UMODE_STOP;
              rstop_q <= cfg.stop_bit_count_select;
            end
          end
        end
        UMODE_PAR: begin
          if (rmid) begin
            rsh_q[8] <= rx_line_q;
            rst_q <= UMODE_STOP;
          end
        end
        UMODE_STOP: begin
          if (rmid) begin
            if (rstop_q && rx_line_q) begin
              rstop_q <= 1'b0;
            end else begin
              rst_q <= UMODE_IDLE;
            end
          end
        end
        default: rst_q <= UMODE_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  umode_st_t tst_q;
  logic [4:0] tsub_q;
  logic [3:0] tidx_q;
  logic [8:0] tsh_q;
  logic tstop_q;
  logic tx_q;
  wire tend = tick & (tsub_q == ovs - 5'h01);
  wire tx_take = (tst_q == UMODE_IDLE) & tx_pend_q & tick;
  assign serial_transmit_line = tx_q;
  // Transmit state machine, one bit per ovs ticks.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tst_q <= UMODE_IDLE;
      tsub_q <= 5'h00;
      tidx_q <= 4'h0;
      tsh_q <= 9'h000;
      tstop_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      if (tick) begin
        tsub_q <= tend ? 5'h00 : tsub_q + 5'h01;
      end
      case (tst_q)
        UMODE_IDLE: begin
          tx_q <= 1'b1;
          if (tx_take) begin
            tst_q <= UMODE_START;
            tsub_q <= 5'h00;
            tsh_q <= txd_q;
            tx_q <= 1'b0;
          end
        end
        UMODE_START: begin
          if (tend) begin
            tst_q <= UMODE_DATA;
            tidx_q <= 4'h0;
            tx_q <= tsh_q[0];
          end
        end
        UMODE_DATA: begin
          if (tend) begin
            tidx_q <= tidx_q + 4'h1;
            if (tidx_q == nbits(cfg.data_parity_select) - 4'h1) begin
              tst_q <= par_on ? UMODE_PAR : UMODE_STOP;
              tx_q <= par_on ? parbit(cfg.data_parity_select, tsh_q[7:0]) : 1'b1;
              tstop_q <= cfg.stop_bit_count_select;
            end else begin
              tx_q <= tsh_q[tidx_q + 4'h1];
            end
          end
        end
        UMODE_PAR: begin
          if (tend) begin
            tst_q <= UMODE_STOP;
            tx_q <= 1'b1;
          end
        end
        UMODE_STOP: begin
          if (tend) begin
            if (tstop_q) begin
              tstop_q <= 1'b0;
            end else begin
              tst_q <= UMODE_IDLE;
            end
          end
        end
        default: tst_q <= UMODE_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Register writes, hardware updates and reads
  // --------------------------------------------------------------------
  // Hardware clear of auto-baud wins over a same-cycle write, since the
  // measurement has finished and the divisor has been replaced.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `UMODE_MODE_RST;
      div_q <= `UMODE_DIV_RST;
      txd_q <= 9'h000;
      tx_pend_q <= 1'b0;
      rxd_q <= 9'h000;
      rx_full_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr && hit_mode) mode_q <= pwdata[15:0] & `UMODE_MODE_MASK;
      if (ab_done) mode_q[`UMODE_BIT_AUTO_RATE_MEASURE_ENABLE] <= 1'b0;
      if (ab_done) div_q <= ab_div[15:0] - 16'h0001;
      else if (wr && hit_div) div_q <= pwdata[15:0];
      if (wr && hit_tx && !tx_pend_q) begin
        txd_q <= pwdata[8:0];
        tx_pend_q <= 1'b1;
      end else if (tx_take) begin
        tx_pend_q <= 1'b0;
      end
      // Receive flags: a new character wins over a clearing access.
      if (rx_done) begin
        rxd_q <= rx_char;
        rx_full_q <= 1'b1;
        perr_q <= rx_perr_d;
        ferr_q <= ~rx_line_q;
      end else begin
        if (rd_first && hit_rx) rx_full_q <= 1'b0;
        if (wr && hit_st) begin
          perr_q <= perr_q & ~pwdata[2];
          ferr_q <= ferr_q & ~pwdata[3];
        end
      end
      if (rd_first) begin
        prdata_q <= hit_mode ? {16'h0000, mode_q} :
                    hit_div ? {16'h0000, div_q} :
                    hit_rx ? {23'h000000, rxd_q} :
                    hit_st ? {28'h0000000, ferr_q, perr_q, rx_full_q, tx_pend_q} :
                    32'h00000000;
      end
    end
  end
endmodule

// >>> rtl/umode_defines.svh
// Offsets, field positions, reset values and timing counts of the mode block.
`ifndef UMODE_DEFINES_SVH
`define UMODE_DEFINES_SVH
`define UMODE_OFF_MODE 12'h000
`define UMODE_OFF_DIV 12'h004
`define UMODE_OFF_TXDATA 12'h008
`define UMODE_OFF_RXDATA 12'h00C
`define UMODE_OFF_STATUS 12'h010
`define UMODE_BIT_STOP 0
`define UMODE_BIT_HS 3
`define UMODE_BIT_INV 4
`define UMODE_BIT_AUTO_RATE_MEASURE_ENABLE 5
`define UMODE_MODE_MASK 16'h003F
`define UMODE_MODE_RST 16'h0000
`define UMODE_DIV_RST 16'h0000
`define UMODE_SYNC_CHAR 8'h55
`define UMODE_OVS_HS 5'h04
`define UMODE_OVS_STD 5'h10
`define UMODE_SYNC_EDGES 3'h4
`endif

// >>> rtl/umode_pkg.sv
// Types shared by the mode block.
package umode_pkg;
  // Data and parity selection encodings.
  typedef enum logic [1:0] {
    UMODE_D8_NONE = 2'h0,
    UMODE_D8_EVEN = 2'h1,
    UMODE_D8_ODD = 2'h2,
    UMODE_D9_NONE = 2'h3
  } umode_dps_t;
  // Decoded mode fields travel together.
  typedef struct packed {
    logic auto_rate_measure_enable;
    logic rx_idle_polarity_invert;
    logic high_speed_oversample_select;
    umode_dps_t data_parity_select;
    logic stop_bit_count_select;
  } umode_cfg_t;
  // Transfer state, one-hot.
  typedef enum logic [4:0] {
    UMODE_IDLE = 5'h01,
    UMODE_START = 5'h02,
    UMODE_DATA = 5'h04,
    UMODE_PAR = 5'h08,
    UMODE_STOP = 5'h10
  } umode_st_t;
endpackage

// >>> verification/umode_partner.sv
// Remote serial station that sends frames to the block and receives its frames.
`timescale 1ns/1ps
module umode_partner (
  // Clock and lines.
  input wire logic clk_sys,
  input wire logic dev_tx,
  output logic dev_rx
);
  initial dev_rx = 1'b1;
  // Park the line at its idle level for the chosen polarity.
  task idle(input logic inv);
    @(posedge clk_sys);
    dev_rx <= ~inv;
  endtask
  // Send one frame; bad flips the parity bit, stop count is the caller's.
  task send(input logic [8:0] d, input int nb, input int pm, input int ns, input int bl,
            input logic inv, input logic bad);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < nb; i++) q.push_back(d[i]);
    if (pm == 1) q.push_back(^d[7:0] ^ bad);
    if (pm == 2) q.push_back(~^d[7:0] ^ bad);
    for (int i = 0; i < ns; i++) q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge clk_sys);
      dev_rx <= q[i] ^ inv;
      repeat (bl - 1) @(posedge clk_sys);
    end
  endtask
  // Take one frame from the block, sampling each bit in its middle.
  task get(input int nb, input int pm, input int bl, output logic [8:0] d, output logic p,
           output logic s);
    d = 9'h000;
    p = 1'b1;
    while (dev_tx !== 1'b0) @(posedge clk_sys);
    repeat (bl / 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      repeat (bl) @(posedge clk_sys);
      d[i] = dev_tx;
    end
    if (pm != 0) begin
      repeat (bl) @(posedge clk_sys);
      p = dev_tx;
    end
    repeat (bl) @(posedge clk_sys);
    s = dev_tx;
  endtask
endmodule

// >>> verification/umode_top_assertions.sv
// Checker of the block's bus answers and transmit start-bit timing.
`timescale 1ns/1ps
`include "umode_defines.svh"
module umode_top_assertions (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins.
  input wire logic serial_receive_line,
  input wire logic serial_transmit_line
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  wire acc = psel && penable;
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `UMODE_OFF_STATUS);
  logic [15:0] mode_q; // Last mode written by software.
  logic [15:0] div_q; // Last divisor written; auto-baud loads are not seen.
  logic tx_q; // Transmit line one cycle ago.
  logic [7:0] frm_q; // Cycles left before the stop bits, so data edges are skipped.
  wire [7:0] frm_len = (mode_q[2:1] == 2'h0 ? 8'h09 : 8'h0A) * (mode_q[3] ? 8'h04 : 8'h10);
  wire start_w = !serial_transmit_line && tx_q && (frm_q == 8'h00) && (div_q == 16'h0000);
  // Follow writes and frame position.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 16'h0000;
      div_q <= 16'h0000;
      tx_q <= 1'b1;
      frm_q <= 8'h00;
    end else begin
      if (acc && pwrite && paddr == `UMODE_OFF_MODE) mode_q <= pwdata[15:0];
      if (acc && pwrite && paddr == `UMODE_OFF_DIV) div_q <= pwdata[15:0];
      tx_q <= serial_transmit_line;
      frm_q <= start_w ? frm_len - 8'h01 : (frm_q != 8'h00 ? frm_q - 8'h01 : 8'h00);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence low4_s;
    !serial_transmit_line [*4];
  endsequence
  sequence low8_s;
    !serial_transmit_line [*8];
  endsequence
  write_ready_a: assert property (acc && pwrite |-> pready) else $error("write waited");
  read_wait_a: assert property ($rose(penable) && psel && !pwrite |-> !pready)
    else $error("read without wait");
  read_ready_a: assert property (acc && !pwrite && !pready |=> pready)
    else $error("read never answered");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("bad slave error");
  idle_err_a: assert property (!acc |-> !pslverr) else $error("error outside access");
  mode_read_a: assert property (acc && !pwrite && paddr == `UMODE_OFF_MODE |=>
    prdata[4:0] == $past(mode_q[4:0]) && prdata[31:6] == 26'h0) else $error("mode readback");
  read_hold_a: assert property (!(acc && !pwrite) |=> $stable(prdata)) else $error("read moved");
  fast_start_a: assert property (start_w && mode_q[3] |-> low4_s)
    else $error("short fast start bit");
  std_start_a: assert property (start_w && !mode_q[3] |-> low8_s ##1 low8_s)
    else $error("short start bit");
endmodule
bind umode_top umode_top_assertions chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_receive_line(serial_receive_line),
  .serial_transmit_line(serial_transmit_line));

// >>> verification/uart_mode_low_fields_tb.sv
// Self-checking bench: register access, framing modes, polarity and auto-baud.
`timescale 1ns/1ps
`include "umode_defines.svh"
module uart_mode_low_fields_tb import umode_pkg::*; ();
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_receive_line, serial_transmit_line;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int exp_q[$]; // Model: characters the block should deliver.
  always #5 clk_sys = ~clk_sys;
  umode_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_receive_line(serial_receive_line),
    .serial_transmit_line(serial_transmit_line));
  umode_partner far (.clk_sys(clk_sys), .dev_tx(serial_transmit_line),
    .dev_rx(serial_receive_line));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  // A read waits one cycle in the block; apb takes the data when pready is high.
  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
  endtask
  // Set a mode, settle the line, then discard any stray character and flags.
  task flush(input logic [31:0] m, input logic inv);
    logic [31:0] r;
    wr(`UMODE_OFF_MODE, m);
    far.idle(inv);
    repeat (300) @(posedge clk_sys);
    rd(`UMODE_OFF_RXDATA, r);
    wr(`UMODE_OFF_STATUS, 32'hC);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [8:0] d, g;
    logic p, s;
    int nb, pm, bl;
    umode_dps_t dps;
    void'($urandom(13));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`UMODE_OFF_MODE, r);
    chk(r, 32'h0);
    rd(`UMODE_OFF_DIV, r);
    chk(r, 32'h0);
    apb(12'h014, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    // Every stop, data/parity, speed and polarity setting, both directions.
    for (int m = 0; m < 32; m++) begin
      dps = umode_dps_t'(m[2:1]);
      pm = dps == UMODE_D8_EVEN ? 1 : (dps == UMODE_D8_ODD ? 2 : 0);
      nb = dps == UMODE_D9_NONE ? 9 : 8;
      bl = m[3] ? 4 : 16;
      flush(32'(m), m[4]);
      d = 9'($urandom);
      if (nb == 8) d[8] = 1'b0;
      exp_q.push_back(int'(d));
      far.send(d, nb, pm, m[0] ? 2 : 1, bl, m[4], (pm != 0) && m[0]);
      repeat (8) @(posedge clk_sys);
      rd(`UMODE_OFF_STATUS, r);
      chk(r[3:1], {1'b0, (pm != 0) && m[0], 1'b1});
      rd(`UMODE_OFF_RXDATA, r);
      chk(r, 32'(exp_q.pop_front()));
      wr(`UMODE_OFF_STATUS, 32'hC);
      wr(`UMODE_OFF_TXDATA, {23'h0, d});
      far.get(nb, pm, bl, g, p, s);
      chk({g, p, s}, {d, pm == 1 ? ^d[7:0] : (pm == 2 ? ~^d[7:0] : 1'b1), 1'b1});
    end
    // Second stop bit cut short by the next start bit.
    flush(32'h1, 1'b0);
    far.send(9'h0A5, 8, 0, 1, 16, 1'b0, 1'b0);
    far.send(9'h00F, 8, 0, 2, 16, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    rd(`UMODE_OFF_STATUS, r);
    chk(r[3], 1'b1);
    // Measure a 32-clock bit: divisor becomes 256 / 128 - 1.
    flush(32'h20, 1'b0);
    far.send(9'h055, 8, 0, 1, 32, 1'b0, 1'b0);
    rd(`UMODE_OFF_MODE, r);
    for (int k = 0; k < 20 && r[5] !== 1'b0; k++) rd(`UMODE_OFF_MODE, r);
    chk(r[5], 1'b0);
    rd(`UMODE_OFF_DIV, r);
    chk(r, 32'h1);
    far.send(9'h0C3, 8, 0, 1, 32, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    rd(`UMODE_OFF_RXDATA, r);
    chk(r, 32'hC3);
    close_out;
  end
endmodule
